/* include/tpu_sync_map.svh */
// Register offsets, field positions and reset values of the timer block.
// Assumes a word-indexed register port with 16-bit data.
`ifndef TPU_SYNC_MAP_SVH
`define TPU_SYNC_MAP_SVH
`define OFS_START      5'h00
`define OFS_SYNC       5'h01
`define OFS_IOCTL      5'h02
`define OFS_MODE       5'h03
`define OFS_IRQ_STAT   5'h04
`define OFS_IRQ_MASK   5'h05
`define OFS_PRIM_A     5'h06
`define OFS_PRIM_B     5'h07
`define OFS_BUF_C      5'h08
`define OFS_CNT_BASE   5'h10
`define OFS_CTL_BASE   5'h18
`define MODE_BUF_POS   0
`define MODE_PWM_POS   1
`define CTL_PSC_LSB    0
`define CTL_CLR_LSB    3
`define IRQ_MATCH_A    0
`define IRQ_MATCH_B    1
`define IRQ_CHAN_C     2
`define RST_GEN_REG    16'hffff
`define RST_ZERO       16'h0000
`endif

/* include/tpu_sync_pkg.sv */
// Types shared by the timer block and its bench.
// Assumes tpu_sync_map.svh is on the include path.
`default_nettype none
package tpu_sync_pkg;
    // Register port request, one cycle per access
    typedef struct packed {
        logic [4:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;
    // Drive of one timer pin
    typedef struct packed {
        logic out;
        logic oe;
    } pin_drive_t;
    // Counter clear source of a channel control register
    typedef enum logic [1:0] {
        CLR_NONE = 2'h0,
        CLR_MATCH_A = 2'h1,
        CLR_MATCH_B = 2'h2,
        CLR_SYNC = 2'h3
    } clr_src_t;
endpackage
`default_nettype wire

/* core/tpu_sync_unit.sv */
// Six-channel timer with synchronous preset/clear, channel-0 compare,
// capture, buffer transfer and PWM pin.
// Assumes a single 50 MHz clock and an asynchronous pin on the secondary input.
//
// Decided for this implementation: the register offsets and the plain strobed port.
`include "tpu_sync_map.svh"
`default_nettype none

// Overview of operation
// [RULE1] Control bit 3 low makes the secondary register an output compare register.
// [RULE2] Compare mode with low bits 00 keeps the secondary pin undriven.
// [RULE3] Nonzero compare action starts the pin at the level of bit 2.
// [RULE4] Each compare match: 01 drives low, 10 drives high, 11 toggles.
// [RULE5] Code 1000 captures the counter on a rising pin edge.
// [RULE6] Code 1001 captures the counter on a falling pin edge.
// [RULE7] Code 101x captures the counter on both pin edges.
// [RULE8] Code 11xx captures whenever the channel-1 counter counts.
// [RULE9] No channel-1 capture when its prescaler selects the undivided clock.
// [RULE10] Buffer mode bit set disables capture and compare on the secondary register.
// [RULE11] One counter write presets every synchronized counter together.
// [RULE12] A synchronized channel's clear source clears all synchronized counters; the code acts only on channel 0's clear source.
// [RULE13] Any of channels 0 to 5 may join synchronous operation.
// [RULE14] Software starts each channel last by setting its run bit.
// [RULE15] Buffer mode: compare match A changes output and loads primary from buffer.
// [RULE16] PWM: clear on match B, pin high at match A, low at match B.
// [RULE17] Toggle inverts the current level; disabled output is not driven.
module tpu_sync_unit
    import tpu_sync_pkg::*;
#(
    parameter int NCH = 6,
    parameter int CNT_W = 16
) (
    input wire logic clk,
    input wire logic nrst,
    input wire reg_req_t req,
    output logic [15:0] rdata,
    output logic irq,
    input wire logic sec_pin_in,
    output pin_drive_t sec_pin,
    output pin_drive_t pwm_pin
);

    ////////////////////////////////////////////////////////////////////////
    // Decode helpers

    // Prescaler tick for a 3-bit select: 1, 4, 16 or 64 clocks
    function automatic logic psc_tick(input logic [2:0] sel, input logic [5:0] div);
        unique case (sel)
            3'h0: psc_tick = 1'b1;
            3'h1: psc_tick = (div[1:0] == 2'h0);
            3'h2: psc_tick = (div[3:0] == 4'h0);
            default: psc_tick = (div == 6'h00);
        endcase
    endfunction

    function automatic logic hit(input logic [4:0] a, input logic [4:0] ofs);
        hit = (a == ofs);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // State

    logic [NCH-1:0] run_q;
    logic [NCH-1:0] sync_q;
    logic [3:0] ioc_q;
    logic buf_mode_q;
    logic pwm_mode_q;
    logic [2:0] irq_stat_q;
    logic [2:0] irq_mask_q;
    logic [CNT_W-1:0] prim_a_q;
    logic [CNT_W-1:0] prim_b_q;
    logic [CNT_W-1:0] buf_c_q;
    logic [CNT_W-1:0] cnt_q [NCH];
    logic [2:0] psc_q [NCH];
    clr_src_t clr_q [NCH];
    logic [5:0] div_q;
    logic sec_out_q;
    logic pwm_out_q;
    logic [2:0] pin_sync_q;
    logic pin_lvl_q;
    logic [15:0] rdata_q;

    logic [NCH-1:0] tick;
    logic [NCH-1:0] own_clr;
    logic [NCH-1:0] cnt_wr;
    logic clr_any;
    logic wr_sync_cnt;
    logic match_a;
    logic match_b;
    logic match_c;
    logic cmp_mode;
    logic cap_mode;
    logic pin_rise;
    logic pin_fall;
    logic cap_evt;

    ////////////////////////////////////////////////////////////////////////
    // Shared prescaler

    // Free-running divider; all channels tap the same phase
    always_ff @(posedge clk) begin
        if (!nrst) begin
            div_q <= 6'h00;
        end else begin
            div_q <= div_q + 6'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Counters

    // Compare events of channel 0 sampled on its count tick
    assign match_a = tick[0] && (cnt_q[0] == prim_a_q);
    assign match_b = tick[0] && (cnt_q[0] == prim_b_q);
    assign match_c = tick[0] && (cnt_q[0] == buf_c_q) && cmp_mode;
    assign clr_any = |(own_clr & sync_q); // RULE12
    assign wr_sync_cnt = |(cnt_wr & sync_q);

    generate
        for (genvar i = 0; i < NCH; i++) begin : g_ch
            assign tick[i] = run_q[i] && psc_tick(psc_q[i], div_q);
            assign cnt_wr[i] = req.wr && hit(req.addr, `OFS_CNT_BASE + 5'(i));
            // Only channel 0 owns compare registers
            assign own_clr[i] = (i == 0) && ((clr_q[i] == CLR_MATCH_A && match_a)
                || (clr_q[i] == CLR_MATCH_B && match_b));

            // Software write wins over count, sync clear wins over count
            always_ff @(posedge clk) begin
                if (!nrst) begin
                    cnt_q[i] <= CNT_W'(`RST_ZERO);
                end else if (cnt_wr[i] || (sync_q[i] && wr_sync_cnt)) begin // RULE11
                    cnt_q[i] <= req.wdata[CNT_W-1:0];
                end else if (own_clr[i] || (sync_q[i] && clr_any)) begin // RULE12
                    cnt_q[i] <= CNT_W'(`RST_ZERO);
                end else if (tick[i]) begin // RULE14
                    cnt_q[i] <= cnt_q[i] + CNT_W'(1);
                end
            end

            // Per-channel control: prescale and clear source
            always_ff @(posedge clk) begin
                if (!nrst) begin
                    psc_q[i] <= 3'h0;
                    clr_q[i] <= CLR_NONE;
                end else if (req.wr && hit(req.addr, `OFS_CTL_BASE + 5'(i))) begin
                    psc_q[i] <= req.wdata[`CTL_PSC_LSB +: 3];
                    clr_q[i] <= clr_src_t'(req.wdata[`CTL_CLR_LSB +: 2]);
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Control registers

    // Run and sync bits; any channel may be synchronized
    always_ff @(posedge clk) begin
        if (!nrst) begin
            run_q <= '0;
            sync_q <= '0;
        end else if (req.wr) begin
            if (hit(req.addr, `OFS_START)) begin
                run_q <= req.wdata[NCH-1:0]; // RULE14
            end
            if (hit(req.addr, `OFS_SYNC)) begin
                sync_q <= req.wdata[NCH-1:0]; // RULE13
            end
        end
    end

    // Secondary I/O control and channel-0 mode
    always_ff @(posedge clk) begin
        if (!nrst) begin
            ioc_q <= 4'h0;
            buf_mode_q <= 1'b0;
            pwm_mode_q <= 1'b0;
        end else if (req.wr) begin
            if (hit(req.addr, `OFS_IOCTL)) begin
                ioc_q <= req.wdata[3:0];
            end
            if (hit(req.addr, `OFS_MODE)) begin
                buf_mode_q <= req.wdata[`MODE_BUF_POS];
                pwm_mode_q <= req.wdata[`MODE_PWM_POS];
            end
        end
    end

    assign cmp_mode = !ioc_q[3] && !buf_mode_q; // RULE1 RULE10
    assign cap_mode = ioc_q[3] && !buf_mode_q; // RULE10

    ////////////////////////////////////////////////////////////////////////
    // General registers

    // Primary A reloads from buffer at match A in buffer mode
    always_ff @(posedge clk) begin
        if (!nrst) begin
            prim_a_q <= CNT_W'(`RST_GEN_REG);
            prim_b_q <= CNT_W'(`RST_GEN_REG);
        end else begin
            if (buf_mode_q && match_a) begin
                prim_a_q <= buf_c_q; // RULE15
            end else if (req.wr && hit(req.addr, `OFS_PRIM_A)) begin
                prim_a_q <= req.wdata[CNT_W-1:0];
            end
            if (req.wr && hit(req.addr, `OFS_PRIM_B)) begin
                prim_b_q <= req.wdata[CNT_W-1:0];
            end
        end
    end

    // Capture beats a software write in the same cycle
    always_ff @(posedge clk) begin
        if (!nrst) begin
            buf_c_q <= CNT_W'(`RST_GEN_REG);
        end else if (cap_evt) begin
            buf_c_q <= cnt_q[0];
        end else if (req.wr && hit(req.addr, `OFS_BUF_C)) begin
            buf_c_q <= req.wdata[CNT_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Input capture

    // Three-stage synchroniser; a level counts once stages 2 and 3 agree
    always_ff @(posedge clk) begin
        if (!nrst) begin
            pin_sync_q <= 3'h0;
            pin_lvl_q <= 1'b0;
        end else begin
            pin_sync_q <= {pin_sync_q[1:0], sec_pin_in};
            if (pin_sync_q[1] == pin_sync_q[2]) begin
                pin_lvl_q <= pin_sync_q[2];
            end
        end
    end

    assign pin_rise = pin_sync_q[1] && pin_sync_q[2] && !pin_lvl_q;
    assign pin_fall = !pin_sync_q[1] && !pin_sync_q[2] && pin_lvl_q;

    // Capture source select by the low control bits
    always_comb begin
        cap_evt = 1'b0;
        if (cap_mode) begin
            unique casez (ioc_q[2:0])
                3'b000: cap_evt = pin_rise; // RULE5
                3'b001: cap_evt = pin_fall; // RULE6
                3'b01?: cap_evt = pin_rise || pin_fall; // RULE7
                3'b1??: cap_evt = tick[1] && (psc_q[1] != 3'h0); // RULE8 RULE9
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Output compare pins

    // Writing the control reloads the initial level
    always_ff @(posedge clk) begin
        if (!nrst) begin
            sec_out_q <= 1'b0;
        end else if (req.wr && hit(req.addr, `OFS_IOCTL)) begin
            sec_out_q <= req.wdata[2]; // RULE3
        end else if (match_c) begin
            unique case (ioc_q[1:0]) // RULE4
                2'h1: sec_out_q <= 1'b0;
                2'h2: sec_out_q <= 1'b1;
                2'h3: sec_out_q <= !sec_out_q; // RULE17
                2'h0: sec_out_q <= sec_out_q;
            endcase
        end
    end

    // Enable off for 00 regardless of bit 2
    assign sec_pin.oe = cmp_mode && (ioc_q[1:0] != 2'h0); // RULE2 RULE17
    assign sec_pin.out = sec_out_q;

    // PWM: high at match A, low at match B; B wins if equal
    always_ff @(posedge clk) begin
        if (!nrst) begin
            pwm_out_q <= 1'b0;
        end else if (match_b) begin
            pwm_out_q <= 1'b0; // RULE16
        end else if (match_a) begin
            pwm_out_q <= 1'b1; // RULE15 RULE16
        end
    end

    assign pwm_pin.oe = pwm_mode_q;
    assign pwm_pin.out = pwm_out_q;

    ////////////////////////////////////////////////////////////////////////
    // Interrupts

    // Sticky status, write one to clear; a new event wins over the clear
    always_ff @(posedge clk) begin
        if (!nrst) begin
            irq_stat_q <= 3'h0;
            irq_mask_q <= 3'h0;
        end else begin
            irq_stat_q <= (irq_stat_q & ~((req.wr && hit(req.addr, `OFS_IRQ_STAT))
                ? req.wdata[2:0] : 3'h0)) | {match_c || cap_evt, match_b, match_a};
            if (req.wr && hit(req.addr, `OFS_IRQ_MASK)) begin
                irq_mask_q <= req.wdata[2:0];
            end
        end
    end

    assign irq = |(irq_stat_q & irq_mask_q);

    ////////////////////////////////////////////////////////////////////////
    // Read port

    // Data stands only in the cycle after the read strobe
    always_ff @(posedge clk) begin
        if (!nrst) begin
            rdata_q <= 16'h0000;
        end else if (!req.rd) begin
            rdata_q <= 16'h0000;
        end else if (req.addr >= `OFS_CNT_BASE && req.addr < `OFS_CNT_BASE + 5'(NCH)) begin
            rdata_q <= 16'(cnt_q[req.addr[2:0]]);
        end else if (req.addr >= `OFS_CTL_BASE && req.addr < `OFS_CTL_BASE + 5'(NCH)) begin
            rdata_q <= {11'h000, clr_q[req.addr[2:0]], psc_q[req.addr[2:0]]};
        end else begin
            unique case (req.addr)
                `OFS_START: rdata_q <= 16'(run_q);
                `OFS_SYNC: rdata_q <= 16'(sync_q);
                `OFS_IOCTL: rdata_q <= {12'h000, ioc_q};
                `OFS_MODE: rdata_q <= {14'h0000, pwm_mode_q, buf_mode_q};
                `OFS_IRQ_STAT: rdata_q <= {13'h0000, irq_stat_q};
                `OFS_IRQ_MASK: rdata_q <= {13'h0000, irq_mask_q};
                `OFS_PRIM_A: rdata_q <= 16'(prim_a_q);
                `OFS_PRIM_B: rdata_q <= 16'(prim_b_q);
                `OFS_BUF_C: rdata_q <= 16'(buf_c_q);
                default: rdata_q <= 16'h0000; // Unmapped reads zero
            endcase
        end
    end

    assign rdata = rdata_q;

endmodule // tpu_sync_unit
`default_nettype wire

/* tb/tpu_sync_sva.sv */
// Checker for the timer block, attached to its top module by bind.
// Assumes tpu_sync_pkg and tpu_sync_map.svh are compiled first.
`include "tpu_sync_map.svh"
`default_nettype none
module tpu_sync_sva
    import tpu_sync_pkg::*;
#(
    parameter int NCH = 6,
    parameter int CNT_W = 16
) (
    input wire logic clk,
    input wire logic nrst,
    input wire reg_req_t req,
    input wire logic [15:0] rdata,
    input wire logic irq,
    input wire logic sec_pin_in,
    input wire pin_drive_t sec_pin,
    input wire pin_drive_t pwm_pin
);
    logic [3:0] ioc_q;
    logic [1:0] mode_q;
    logic [2:0] mask_q;
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    // Shadow copies of the I/O control, mode and interrupt mask fields, kept from bus writes
    always_ff @(posedge clk) begin
        if (!nrst) begin
            ioc_q <= 4'h0;
            mode_q <= 2'h0;
            mask_q <= 3'h0;
        end else if (req.wr) begin
            if (req.addr == `OFS_IOCTL) ioc_q <= req.wdata[3:0];
            if (req.addr == `OFS_MODE) mode_q <= req.wdata[1:0];
            if (req.addr == `OFS_IRQ_MASK) mask_q <= req.wdata[2:0];
        end
    end
    ////////////////////////////////////////////////////////////////////////
    rd_idle_a: assert property (!$past(req.rd) |-> rdata == 16'h0000)
        else $error("read data not zero outside its slot");
    rd_mode_a: assert property ($past(req.rd && req.addr == `OFS_MODE) |->
        rdata == {14'h0000, $past(mode_q)}) else $error("mode read back wrong");
    rd_unmapped_a: assert property ($past(req.rd && req.addr == 5'h09) |-> rdata == 16'h0000)
        else $error("unmapped read not zero");
    irq_masked_a: assert property (mask_q == 3'h0 |-> !irq)
        else $error("interrupt with all sources masked");
    irq_fall_a: assert property ($fell(irq) |->
        $past(req.wr && (req.addr == `OFS_IRQ_STAT || req.addr == `OFS_IRQ_MASK)))
        else $error("interrupt dropped without a status or mask write");
    buf_quiet_a: assert property (mode_q[0] |-> !sec_pin.oe)
        else $error("secondary pin driven in buffer mode");
    capture_quiet_a: assert property (ioc_q[3] |-> !sec_pin.oe)
        else $error("secondary pin driven in capture mode");
    action_off_a: assert property (!ioc_q[3] && ioc_q[1:0] == 2'h0 |-> !sec_pin.oe)
        else $error("secondary pin driven with no action");
    compare_drive_a: assert property (!ioc_q[3] && ioc_q[1:0] != 2'h0 && !mode_q[0]
        |-> sec_pin.oe) else $error("secondary pin not driven in compare mode");
    init_level_a: assert property ($past(req.wr && req.addr == `OFS_IOCTL) |->
        sec_pin.out == $past(req.wdata[2])) else $error("initial pin level wrong");
    pwm_enable_a: assert property (pwm_pin.oe == mode_q[1])
        else $error("pulse pin enable differs from mode");
endmodule // tpu_sync_sva
bind tpu_sync_unit tpu_sync_sva #(.NCH(NCH), .CNT_W(CNT_W)) tpu_sync_sva_inst (.clk(clk),
    .nrst(nrst), .req(req), .rdata(rdata), .irq(irq), .sec_pin_in(sec_pin_in),
    .sec_pin(sec_pin), .pwm_pin(pwm_pin));
`default_nettype wire

/* tb/pin_partner.sv */
// External side of the secondary timer pin.
// Assumes the bench calls set_level between requests; changes land after an edge.
`default_nettype none
module pin_partner
    import tpu_sync_pkg::*;
(
    input wire logic clk,
    input wire pin_drive_t sec_pin,
    output logic sec_pin_in
);
    logic ext_q;
    initial ext_q = 1'b0;
    // Wire level: the block wins while it drives, else the outside source
    assign sec_pin_in = sec_pin.oe ? sec_pin.out : ext_q;
    // Outside level moves only just after a rising edge
    task automatic set_level(input logic v);
        @(posedge clk);
        ext_q <= v;
    endtask
endmodule // pin_partner
`default_nettype wire

/* tb/testbench.sv */
// Self-checking bench for the timer block.
// Assumes the package, the register map header and the pin partner are compiled first.
`include "tpu_sync_map.svh"
`default_nettype none
module testbench
    import tpu_sync_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, nrst, irq, sec_pin_in;
    reg_req_t req;
    logic [15:0] rdata;
    pin_drive_t sec_pin, pwm_pin;
    int n_mismatch = 0;
    int cmp_count = 0;
    tpu_sync_unit tpu_sync_unit_inst (.clk(clk), .nrst(nrst), .req(req), .rdata(rdata),
        .irq(irq), .sec_pin_in(sec_pin_in), .sec_pin(sec_pin), .pwm_pin(pwm_pin));
    pin_partner pin_partner_inst (.clk(clk), .sec_pin(sec_pin), .sec_pin_in(sec_pin_in));
    ////////////////////////////////////////////////////////////////////////
    // Shared checking and bus tasks; one idle cycle between accesses
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    function automatic logic [15:0] b16(input logic x);
        return {15'h0000, x};
    endfunction
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge clk);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        req.wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [4:0] a, input logic [15:0] exp);
        @(posedge clk);
        req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        req.rd <= 1'b0;
        #1 check(rdata, exp);
    endtask
    task automatic run_for(input logic [15:0] bits);
        wr(`OFS_START, bits);
        repeat (20) @(posedge clk);
        #1;
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        rd(`OFS_PRIM_A, `RST_GEN_REG);
        rd(`OFS_PRIM_B, `RST_GEN_REG);
        rd(`OFS_BUF_C, `RST_GEN_REG);
        rd(`OFS_CNT_BASE, `RST_ZERO);
        rd(5'h09, 16'h0000);
    endtask
    // Every compare code: enable, initial level, action at match C, flag
    task automatic t_compare();
        logic [3:0] c;
        logic exp;
        wr(`OFS_BUF_C, 16'h0005);
        wr(`OFS_IRQ_MASK, 16'h0004);
        for (int i = 0; i < 8; i++) begin
            c = i[3:0];
            wr(`OFS_START, 16'h0000);
            wr(`OFS_CNT_BASE, 16'h0000);
            wr(`OFS_IOCTL, {12'h000, c});
            check(b16(sec_pin.oe), b16(c[1:0] != 2'h0));
            check(b16(sec_pin.out), b16(c[2]));
            run_for(16'h0001);
            exp = (c[1:0] == 2'h1) ? 1'b0 : (c[1:0] == 2'h2) ? 1'b1 : ~c[2];
            if (c[1:0] != 2'h0) check(b16(sec_pin.out), b16(exp));
            check(b16(irq), 16'h0001);
            wr(`OFS_IRQ_STAT, 16'h0004);
            check(b16(irq), 16'h0000);
        end
    endtask
    // Frozen counter so each captured value is known exactly
    task automatic t_capture();
        logic [3:0] c;
        logic [15:0] prev;
        prev = 16'h0000;
        wr(`OFS_START, 16'h0000);
        wr(`OFS_BUF_C, prev);
        for (int i = 8; i < 11; i++) begin
            c = i[3:0];
            wr(`OFS_IOCTL, {12'h000, c});
            wr(`OFS_CNT_BASE, {12'h010, c});
            pin_partner_inst.set_level(1'b1);
            repeat (8) @(posedge clk);
            if (c != 4'h9) prev = {12'h010, c};
            rd(`OFS_BUF_C, prev);
            wr(`OFS_CNT_BASE, {12'h020, c});
            pin_partner_inst.set_level(1'b0);
            repeat (8) @(posedge clk);
            if (c != 4'h8) prev = {12'h020, c};
            rd(`OFS_BUF_C, prev);
        end
        wr(`OFS_IOCTL, 16'h000c);
        wr(`OFS_CNT_BASE, 16'h0777);
        wr(`OFS_CTL_BASE + 5'h01, 16'h0000);
        run_for(16'h0002);
        rd(`OFS_BUF_C, prev);
        wr(`OFS_CTL_BASE + 5'h01, 16'h0001);
        run_for(16'h0002);
        rd(`OFS_BUF_C, 16'h0777);
    endtask
    // Buffer mode: match A loads A from C; C lies below A so a stray
    // compare on C would raise the unmasked channel-C flag
    task automatic t_buffer();
        wr(`OFS_START, 16'h0000);
        wr(`OFS_IRQ_STAT, 16'h0007);
        wr(`OFS_MODE, 16'h0001);
        rd(`OFS_MODE, 16'h0001);
        wr(`OFS_IOCTL, 16'h0001);
        check(b16(sec_pin.oe), 16'h0000);
        wr(`OFS_PRIM_A, 16'h0005);
        wr(`OFS_BUF_C, 16'h0003);
        wr(`OFS_CNT_BASE, 16'h0000);
        run_for(16'h0001);
        check(b16(irq), 16'h0000);
        wr(`OFS_START, 16'h0000);
        rd(`OFS_PRIM_A, 16'h0003);
        wr(`OFS_MODE, 16'h0000);
    endtask
    // Preset and clear across channels 0, 1 and 5; channel 3 stays out
    task automatic t_sync();
        wr(`OFS_SYNC, 16'h0023);
        wr(`OFS_CNT_BASE + 5'h05, 16'h0042);
        rd(`OFS_CNT_BASE, 16'h0042);
        rd(`OFS_CNT_BASE + 5'h01, 16'h0042);
        rd(`OFS_CNT_BASE + 5'h03, 16'h0000);
        wr(`OFS_PRIM_A, 16'h0042);
        wr(`OFS_CTL_BASE, 16'h000b);
        wr(`OFS_CTL_BASE + 5'h01, 16'h0003);
        // Same slow rate on channel 5, so it cannot move before the stop lands
        wr(`OFS_CTL_BASE + 5'h05, 16'h0003);
        wr(`OFS_IRQ_STAT, 16'h0007);
        wr(`OFS_IRQ_MASK, 16'h0001);
        wr(`OFS_START, 16'h0023);
        for (int k = 0; k < 100 && irq !== 1'b1; k++) @(posedge clk);
        wr(`OFS_START, 16'h0000);
        rd(`OFS_CNT_BASE, 16'h0000);
        rd(`OFS_CNT_BASE + 5'h01, 16'h0000);
        rd(`OFS_CNT_BASE + 5'h05, 16'h0000);
    endtask
    // Pulse pin: period 7, high from the cycle after match A to match B
    task automatic t_pwm();
        logic [15:0] n;
        n = 16'h0000;
        wr(`OFS_MODE, 16'h0002);
        check(b16(pwm_pin.oe), 16'h0001);
        wr(`OFS_PRIM_A, 16'h0002);
        wr(`OFS_PRIM_B, 16'h0006);
        wr(`OFS_CTL_BASE, 16'h0010);
        wr(`OFS_CNT_BASE, 16'h0000);
        run_for(16'h0001);
        repeat (7) begin
            @(posedge clk);
            #1 n = n + b16(pwm_pin.out);
        end
        check(n, 16'h0004);
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // Whole run is several hundred cycles; this cuts a hang short
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        close_out();
    end
    initial begin
        req = '0;
        nrst = 1'b0;
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        t_reset();
        t_compare();
        t_capture();
        t_buffer();
        t_sync();
        t_pwm();
        close_out();
    end
endmodule // testbench
`default_nettype wire
